/* hw/cwg_top.sv */
/*
  Complementary waveform generator: four drive outputs from one
  selected input, with steering, bridge and push-pull modes, dead
  bands and auto-shutdown, reached over a classic Wishbone slave.
  Assumes all inputs are synchronous to clk_i; the generator clock
  choice only steers the oscillator keep-alive output.
*/
`timescale 1ns/1ps

// Operation
// - Steering mode: any outputs carry input or fixed
// - Steered follows input; unsteered holds fixed level
// - Polarity applies only to steered outputs
// - Shutdown overrides only steered outputs
// - Mode 000 steer write acts immediately
// - Mode 001 steer applies at input rise
// - Writing shutdown bit forces shutdown state
// - Without restart, shutdown lasts while bit set
// - Enabled source forces override levels at once
// - Shutdown sources are active low
// - Sources level sensitive; hold shutdown while asserted
// - Keep fast oscillator when enabled, active, selected
// - Override fields set levels, polarity used only by code 0
// - Software clear refused while source asserted
// - Overrides hold until first input rise
// - Auto-restart clears bit when sources release
// - Auto-restart ends software shutdown too
// - Control bit 7 enables generator
// - Load bit transfers dead bands, self clears
// - Load settable only when already enabled
// - Mode field selects six modes, two reserved
// - Half-bridge: true/inverted with dead bands
// - Push-pull alternates, starts A, resets
// - Full-bridge forward and reverse static levels
// - Dead band counts clocks to programmed value
module cwg_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cwg_pkg::cwg_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] src_i,
  input wire logic [3:0] shutdown_n_i,
  output logic [3:0] out_o,
  output logic [3:0] out_oe_o,
  output logic osc_keep_o
);
  import cwg_pkg::*;

  cwg_state_t s;
  cwg_state_t next_s;
  logic in_sel;
  logic rise;
  logic fall;
  logic src_act;
  logic wr;
  logic [7:0] wd;
  logic sw_set;
  logic ovr;
  logic [3:0] steer_eff;
  logic [3:0] raw;
  logic [3:0] polmask;
  logic [3:0] ovmask;
  logic [3:0] fin;
  logic [3:0] fin_oe;
  logic [5:0] d_tgt;

  // ----------------------------------------------------------------
  // Input edges and shutdown sources
  // ----------------------------------------------------------------
  // Selected input and its edges
  assign in_sel = src_i[s.isel];
  assign rise = in_sel & ~s.in_q;
  assign fall = ~in_sel & s.in_q;
  // Low level on an enabled source asserts shutdown
  assign src_act = |(s.sden & ~shutdown_n_i);
  // Write commits at the edge where the master sees ack
  assign wr = wb_i.cyc & wb_i.stb & wb_i.we & s.ack & wb_i.sel[0];
  assign wd = wb_i.dat[7:0];
  assign sw_set = wr && wb_i.adr == ADR_SD0 && wd[SD_B];
  // Source or write overrides in the same cycle, not a cycle later
  assign ovr = s.st != ST_RUN || src_act || sw_set;
  // Immediate mode reads the register itself
  assign steer_eff = s.mode == MD_IMM ? s.steer : s.steer_act;
  assign d_tgt = s.dir_fwd ? s.dbf_a : s.dbr_a;

  // ----------------------------------------------------------------
  // Raw waveform per mode
  // ----------------------------------------------------------------
  // Pre-polarity levels; 0 is the inactive level everywhere
  always_comb begin
    raw = 4'h0;
    polmask = 4'hF;
    ovmask = 4'hF;
    if (s.en) begin
      case (s.mode)
        MD_IMM, MD_SYNC: begin
          // Steered carry the input, others their fixed level
          for (int i = 0; i < 4; i++) begin
            raw[i] = steer_eff[i] ? in_sel : s.fix[i];
          end
          polmask = steer_eff;
          ovmask = steer_eff;
        end
        MD_FWD, MD_REV: begin
          // Direction latched at input rise, modulated leg delayed
          raw[0] = s.dir_fwd;
          raw[2] = ~s.dir_fwd;
          raw[3] = s.dir_fwd & in_sel & (s.cnt_d == d_tgt);
          raw[1] = ~s.dir_fwd & in_sel & (s.cnt_d == d_tgt);
        end
        MD_HALF: begin
          raw[0] = in_sel & (s.cnt_r == s.dbr_a);
          raw[1] = ~in_sel & (s.cnt_f == s.dbf_a);
          raw[2] = raw[0];
          raw[3] = raw[1];
        end
        MD_PP: begin
          raw[0] = in_sel & ~s.pp;
          raw[1] = in_sel & s.pp;
          raw[2] = raw[0];
          raw[3] = raw[1];
        end
        default: raw = 4'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-output polarity and override
  // ----------------------------------------------------------------
  // Pairs A/C and B/D share one override field
  for (genvar g = 0; g < 4; g++) begin : g_out
    logic [1:0] lev;
    logic hit;
    assign lev = (g % 2 == 0) ? s.override_level_a_c : s.override_level_b_d;
    assign hit = ovr & ovmask[g];
    // Override level ignores polarity except the inactive code
    assign fin[g] = hit ? (lev == LEV_HI ? 1'b1 :
                           lev == LEV_LO ? 1'b0 :
                           lev == LEV_TRI ? 1'b0 : s.pol[g])
                        : raw[g] ^ (polmask[g] & s.pol[g]);
    assign fin_oe[g] = ~(hit & (lev == LEV_TRI));
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus, control registers, counters and shutdown sequencing
  always_comb begin
    next_s = s;
    next_s.in_q = in_sel;
    // One-cycle ack, dropped the cycle after it was given
    next_s.ack = wb_i.cyc & wb_i.stb & ~s.ack;
    next_s.rdat = 8'h00;
    case (wb_i.adr)
      ADR_CTRL0: next_s.rdat = {s.en, s.ld, 3'h0, s.mode};
      ADR_POL: next_s.rdat = {2'h0, in_sel, 1'b0, s.pol};
      ADR_DBR: next_s.rdat = {2'h0, s.dbr};
      ADR_DBF: next_s.rdat = {2'h0, s.dbf};
      ADR_SD0: next_s.rdat = {s.sd, s.ren, s.override_level_b_d, s.override_level_a_c, 2'h0};
      ADR_SDEN: next_s.rdat = {4'h0, s.sden};
      ADR_CTRL2: next_s.rdat = {s.fix, s.steer};
      ADR_ISEL: next_s.rdat = {6'h00, s.isel};
      ADR_CLK: next_s.rdat = {7'h00, s.clk_sel};
      default: next_s.rdat = 8'h00;
    endcase
    // Dead-band load on the next input event clears the request
    if (s.ld && (rise || fall)) begin
      next_s.dbr_a = s.dbr;
      next_s.dbf_a = s.dbf;
      next_s.ld = 1'b0;
    end
    if (wr) begin
      case (wb_i.adr)
        ADR_CTRL0: begin
          next_s.en = wd[EN_B];
          next_s.mode = wd[2:0];
          // Load only when enable was already set
          if (wd[LD_B] && s.en) begin
            next_s.ld = 1'b1;
          end
        end
        ADR_POL: next_s.pol = wd[3:0];
        ADR_DBR: next_s.dbr = wd[5:0];
        ADR_DBF: next_s.dbf = wd[5:0];
        ADR_SD0: begin
          next_s.sd = wd[SD_B];
          next_s.ren = wd[REN_B];
          next_s.override_level_b_d = wd[5:4];
          next_s.override_level_a_c = wd[3:2];
        end
        ADR_SDEN: next_s.sden = wd[3:0];
        ADR_CTRL2: begin
          next_s.steer = wd[3:0];
          next_s.fix = wd[7:4];
        end
        ADR_ISEL: next_s.isel = wd[1:0];
        ADR_CLK: next_s.clk_sel = wd[0];
        default: next_s.en = s.en;
      endcase
    end
    // Disabled block loads dead bands straight through
    if (!s.en) begin
      next_s.dbr_a = next_s.dbr;
      next_s.dbf_a = next_s.dbf;
    end
    // Auto-restart clears once sources release, unless set now
    if (s.ren && !src_act && !sw_set) begin
      next_s.sd = 1'b0;
    end
    // Asserted source sets and wins over any clear
    if (src_act) begin
      next_s.sd = 1'b1;
    end
    // Synchronous steering takes new bits at input rise
    if (rise) begin
      next_s.steer_act = s.steer;
    end
    // Shutdown sequencer
    case (s.st)
      ST_RUN: if (next_s.sd) next_s.st = ST_SHUT;
      ST_SHUT: if (!s.sd) next_s.st = ST_HOLD;
      ST_HOLD: begin
        if (next_s.sd) begin
          next_s.st = ST_SHUT;
        end else if (rise) begin
          next_s.st = ST_RUN;
        end
      end
      default: next_s.st = ST_SHUT;
    endcase
    // Push-pull phase flips after each pulse
    if (!s.en || ovr) begin
      next_s.pp = 1'b0;
    end else if (fall) begin
      next_s.pp = ~s.pp;
    end
    // Dead-band counters count clocks up to the value
    if (!in_sel) begin
      next_s.cnt_r = 6'h00;
    end else if (s.cnt_r != s.dbr_a) begin
      next_s.cnt_r = s.cnt_r + 6'h01;
    end
    if (in_sel) begin
      next_s.cnt_f = 6'h00;
    end else if (s.cnt_f != s.dbf_a) begin
      next_s.cnt_f = s.cnt_f + 6'h01;
    end
    // Direction change restarts the bridge dead band
    if (rise && s.dir_fwd != ~s.mode[0]) begin
      next_s.dir_fwd = ~s.mode[0];
      next_s.cnt_d = 6'h00;
    end else if (s.cnt_d != d_tgt) begin
      next_s.cnt_d = s.cnt_d + 6'h01;
    end
    // Input counts as active for a while after any edge
    if (rise || fall) begin
      next_s.act_cnt = IN_ACT_CYC;
    end else if (s.act_cnt != 8'h00) begin
      next_s.act_cnt = s.act_cnt - 8'h01;
    end
    next_s.osc_keep = s.en & s.clk_sel & (s.act_cnt != 8'h00);
    next_s.out = fin;
    next_s.oe = fin_oe;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Start in run state with shutdown clear and output enables low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ST_RUN;
      s.override_level_b_d <= SD0_OVERRIDE_LEVEL_B_D_RST;
      s.override_level_a_c <= SD0_OVERRIDE_LEVEL_A_C_RST;
      s.dir_fwd <= 1'b1;
      s.oe <= 4'h0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdat};
  assign out_o = s.out;
  assign out_oe_o = s.oe;
  assign osc_keep_o = s.osc_keep;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence sq_steer_run;
    s.en && s.mode == MD_IMM && !ovr && s.steer[0];
  endsequence
  sequence sq_ld_req;
    wr && wb_i.adr == ADR_CTRL0 && wd[LD_B] && !s.en && !s.ld;
  endsequence
  sequence sq_half_on;
    s.en && s.mode == MD_HALF && !ovr && in_sel && s.cnt_r == s.dbr_a;
  endsequence

  chk_steer_follow: assert property (
    sq_steer_run |=> out_o[0] == $past(in_sel ^ s.pol[0]))
    else $error("steered output does not follow input");
  chk_fixed_level: assert property (
    s.en && s.mode == MD_IMM && !s.steer[1]
    |=> out_o[1] == $past(s.fix[1]) && out_oe_o[1])
    else $error("unsteered output left its fixed level");
  chk_sw_shutdown: assert property (
    sw_set |=> s.sd ##1 s.st != ST_RUN)
    else $error("software shutdown not entered");
  chk_src_hold: assert property (
    src_act |=> s.sd)
    else $error("shutdown bit cleared under active source");
  chk_auto_clear: assert property (
    s.sd && s.ren && !src_act && !sw_set |=> !s.sd)
    else $error("auto-restart did not clear shutdown");
  chk_hold_rise: assert property (
    s.st == ST_HOLD && !rise |=> s.st != ST_RUN)
    else $error("overrides released before input rise");
  chk_ld_clear: assert property (
    s.ld && (rise || fall) |=> !s.ld && s.dbr_a == $past(s.dbr))
    else $error("dead-band load not performed");
  chk_ld_refused: assert property (
    sq_ld_req |=> !s.ld)
    else $error("load accepted while disabled");
  chk_reserved_idle: assert property (
    s.en && s.mode[2:1] == 2'b11 && !ovr |=> out_o == $past(s.pol))
    else $error("reserved mode drove an active level");
  chk_pp_reset: assert property (
    !s.en |=> !s.pp)
    else $error("push-pull phase not reset");

  // Override levels and shutdown response
  chk_ovr_level: assert property (
    ovr && s.en && s.mode == MD_IMM && s.steer[0] && s.override_level_a_c == LEV_HI
    |=> out_o[0] && out_oe_o[0])
    else $error("override level not driven");
  chk_ovr_float: assert property (
    ovr && s.mode[2:1] != 2'b00 && s.override_level_a_c == LEV_TRI
    |=> !out_oe_o[0] && !out_oe_o[2])
    else $error("tri-state override still driving");
  chk_ovr_at_once: assert property (
    src_act && s.en && s.mode == MD_IMM && s.steer[0]
    && s.override_level_a_c == LEV_HI |=> out_o[0])
    else $error("source did not override at once");
  // Steering and disabled levels
  chk_disabled_pol: assert property (
    !s.en && !ovr |=> out_o == $past(s.pol) && out_oe_o == 4'hF)
    else $error("disabled block left its idle levels");
  chk_imm_steer: assert property (
    wr && wb_i.adr == ADR_CTRL2 && s.mode == MD_IMM
    |=> steer_eff == $past(wd[3:0]))
    else $error("immediate steering did not apply");
  chk_sync_latch: assert property (
    s.mode == MD_SYNC && !rise |=> $stable(s.steer_act))
    else $error("synchronous steering changed off an input rise");
  // Bridge, push-pull, dead band and oscillator
  chk_half_lead: assert property (
    sq_half_on |=> out_o[0] == !$past(s.pol[0])
    && out_o[1] == $past(s.pol[1]))
    else $error("half-bridge leading output wrong");
  chk_db_count: assert property (
    in_sel && s.cnt_r != s.dbr_a |=> s.cnt_r == $past(s.cnt_r) + 6'h01)
    else $error("dead-band counter skipped a clock");
  chk_fwd_static: assert property (
    s.en && s.mode == MD_FWD && s.dir_fwd && !ovr
    |=> out_o[0] == !$past(s.pol[0]) && out_o[2] == $past(s.pol[2]))
    else $error("forward bridge static legs wrong");
  chk_pp_alt: assert property (
    s.en && s.mode == MD_PP && !ovr && fall |=> s.pp != $past(s.pp))
    else $error("push-pull did not alternate");
  chk_osc_gate: assert property (
    !s.en || !s.clk_sel |=> !osc_keep_o)
    else $error("oscillator kept while not needed");

endmodule // cwg_top

/* hw/cwg_pkg.sv */
/*
  Shared constants and types of the complementary waveform generator.
  Assumes a 32-bit classic Wishbone slave port; each register is one
  aligned word with its data in the low byte.
*/
package cwg_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL0 = 8'h00;
  localparam logic [7:0] ADR_POL = 8'h04;
  localparam logic [7:0] ADR_DBR = 8'h08;
  localparam logic [7:0] ADR_DBF = 8'h0C;
  localparam logic [7:0] ADR_SD0 = 8'h10;
  localparam logic [7:0] ADR_SDEN = 8'h14;
  localparam logic [7:0] ADR_CTRL2 = 8'h18;
  localparam logic [7:0] ADR_ISEL = 8'h1C;
  localparam logic [7:0] ADR_CLK = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EN_B = 7;
  localparam int LD_B = 6;
  localparam int IN_B = 5;
  localparam int SD_B = 7;
  localparam int REN_B = 6;
  localparam logic [1:0] SD0_OVERRIDE_LEVEL_B_D_RST = 2'h1;
  localparam logic [1:0] SD0_OVERRIDE_LEVEL_A_C_RST = 2'h1;

  // Override level codes
  localparam logic [1:0] LEV_HI = 2'h3;
  localparam logic [1:0] LEV_LO = 2'h2;
  localparam logic [1:0] LEV_TRI = 2'h1;

  // Cycles an input edge keeps the input counted as active
  localparam logic [7:0] IN_ACT_CYC = 8'hFF;

  // Operating modes
  localparam logic [2:0] MD_IMM = 3'h0;
  localparam logic [2:0] MD_SYNC = 3'h1;
  localparam logic [2:0] MD_FWD = 3'h2;
  localparam logic [2:0] MD_REV = 3'h3;
  localparam logic [2:0] MD_HALF = 3'h4;
  localparam logic [2:0] MD_PP = 3'h5;

  // Shutdown sequencer, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SHUT = 3'b010,
    ST_HOLD = 3'b100
  } cwg_st_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cwg_wb_req_t;

  typedef struct packed {
    logic en; logic ld; logic [2:0] mode; logic [3:0] pol;
    logic [5:0] dbr; logic [5:0] dbf; logic [5:0] dbr_a;
    logic [5:0] dbf_a; logic sd; logic ren; logic [1:0] override_level_b_d;
    logic [1:0] override_level_a_c; logic [3:0] sden; logic [3:0] steer;
    logic [3:0] fix; logic [3:0] steer_act; logic [1:0] isel;
    logic clk_sel; logic in_q; cwg_st_t st; logic pp;
    logic [5:0] cnt_r; logic [5:0] cnt_f; logic dir_fwd;
    logic [5:0] cnt_d; logic [7:0] act_cnt; logic ack;
    logic [7:0] rdat; logic [3:0] out; logic [3:0] oe;
    logic osc_keep;
  } cwg_state_t;

endpackage

/* bench/cwg_switch_model.sv */
/*
  Gate driver stand-in for the four drive outputs.
  Assumes each enable is high while the generator drives its pin.
*/
`timescale 1ns/1ps
module cwg_switch_model (
  input wire logic clk_i,
  input wire logic [3:0] drv_i,
  input wire logic [3:0] oe_i,
  output logic [3:0] pin_o
);
  logic [3:0] last = 4'h0;
  // ----
  // Pin level
  // ----
  // A floating gate never keeps its last level: it flips each cycle
  always @(posedge clk_i) begin
    last <= pin_o;
  end
  assign pin_o = (oe_i & drv_i) | (~oe_i & ~last);
endmodule // cwg_switch_model

/* bench/testbench.sv */
/*
  Self-checking bench for the waveform generator: registers over
  classic Wishbone, steering, bridges, push-pull and shutdown.
  Assumes the switch model shows the levels seen by the gates.
*/
`timescale 1ns/1ps
module testbench;
  import cwg_pkg::*;
  logic clk_i, rst_i, ack, osc;
  cwg_wb_req_t wb;
  logic [31:0] rd;
  logic [3:0] src, sdn, out, oe, pin;
  logic [7:0] q;
  int n_mismatch, check_count;

  cwg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(ack),
    .wb_dat_o(rd), .src_i(src), .shutdown_n_i(sdn), .out_o(out),
    .out_oe_o(oe), .osc_keep_o(osc));
  cwg_switch_model sw (.clk_i(clk_i), .drv_i(out), .oe_i(oe),
    .pin_o(pin));

  // ----
  // Helpers
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb <= '{1'h1, 1'h1, w, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'h1 && k < 20);
    if (ack !== 1'h1) begin
      n_mismatch++;
      wrap_up();
    end
    q = rd[7:0];
    wb <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h0);
    cmp(q, e);
  endtask
  // Input level change, then time for the output register
  task automatic drv(input logic v);
    @(posedge clk_i);
    src <= {3'h0, v};
    tick(4);
  endtask
  task automatic ochk(input logic [3:0] e);
    tick(2);
    cmp({4'h0, pin}, {4'h0, e});
  endtask
  task automatic sd_src(input logic [3:0] v);
    @(posedge clk_i);
    sdn <= v;
    tick(3);
  endtask

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    n_mismatch = 0;
    check_count = 0;
    rst_i = 1'h1;
    wb = '0;
    src = 4'h0;
    sdn = 4'hF;
    tick(12);
    rst_i <= 1'h0;
    // Reset values, unmapped word; setup order kept below
    rchk(ADR_CTRL0, 8'h00);
    rchk(ADR_SD0, 8'h14);
    wr(8'h3C, 8'hFF);
    rchk(8'h3C, 8'h00);
    wr(ADR_DBR, 8'h00);
    wr(ADR_DBF, 8'h00);
    wr(ADR_ISEL, 8'h00);
    wr(ADR_POL, 8'h00);
    $display("test registers done");
    // Immediate steering: A, C steered; B fixed high
    wr(ADR_CTRL2, 8'h25);
    wr(ADR_CTRL0, {5'h10, MD_IMM});
    drv(1'h1);
    ochk(4'h7);
    wr(ADR_POL, 8'h0F);
    ochk(4'h2);
    wr(ADR_POL, 8'h00);
    wr(ADR_CTRL2, 8'h21);
    ochk(4'h3);
    $display("test immediate steering done");
    // Synchronous steering waits for an input rise
    wr(ADR_CTRL0, {5'h10, MD_SYNC});
    drv(1'h0);
    drv(1'h1);
    wr(ADR_CTRL2, 8'h25);
    ochk(4'h3);
    drv(1'h0);
    ochk(4'h2);
    drv(1'h1);
    ochk(4'h7);
    $display("test sync steering done");
    // Software shutdown, overrides A/C high, B/D low
    wr(ADR_CTRL0, {5'h10, MD_IMM});
    wr(ADR_CTRL2, 8'h0F);
    ochk(4'hF);
    wr(ADR_SD0, 8'hAC);
    ochk(4'h5);
    wr(ADR_POL, 8'h0F);
    ochk(4'h5);
    rchk(ADR_SD0, 8'hAC);
    tick(20);
    ochk(4'h5);
    wr(ADR_CTRL2, 8'h21);
    ochk(4'h3);
    wr(ADR_POL, 8'h00);
    wr(ADR_SD0, 8'h2C);
    drv(1'h0);
    ochk(4'h3);
    drv(1'h1);
    drv(1'h0);
    ochk(4'h2);
    $display("test software shutdown done");
    // Source shutdown, refused clear, auto-restart
    wr(ADR_SDEN, 8'h01);
    sd_src(4'hE);
    ochk(4'h3);
    wr(ADR_SD0, 8'h2C);
    rchk(ADR_SD0, 8'hAC);
    sd_src(4'hF);
    wr(ADR_SD0, 8'h2C);
    rchk(ADR_SD0, 8'h2C);
    wr(ADR_SD0, 8'h6C);
    sd_src(4'hE);
    rchk(ADR_SD0, 8'hEC);
    sd_src(4'hF);
    rchk(ADR_SD0, 8'h6C);
    wr(ADR_SD0, 8'hEC);
    tick(3);
    rchk(ADR_SD0, 8'h6C);
    wr(ADR_SD0, 8'h2C);
    $display("test source shutdown done");
    // Full bridge forward then reverse
    wr(ADR_CTRL0, {5'h10, MD_FWD});
    drv(1'h1);
    ochk(4'h9);
    drv(1'h0);
    ochk(4'h1);
    wr(ADR_CTRL0, {5'h10, MD_REV});
    drv(1'h1);
    ochk(4'h6);
    drv(1'h0);
    ochk(4'h4);
    $display("test full bridge done");
    // Push-pull restarts on A after disable
    wr(ADR_CTRL0, 8'h00);
    ochk(4'h0);
    wr(ADR_CTRL0, {5'h10, MD_PP});
    drv(1'h1);
    ochk(4'h5);
    drv(1'h0);
    drv(1'h1);
    ochk(4'hA);
    drv(1'h0);
    $display("test push-pull done");
    // Half bridge with a rising dead band of four clocks
    wr(ADR_CTRL0, 8'h00);
    wr(ADR_DBR, 8'h04);
    wr(ADR_CTRL0, {5'h10, MD_HALF});
    drv(1'h0);
    @(posedge clk_i);
    src <= 4'h1;
    tick(1);
    ochk(4'h0);
    ochk(4'h0);
    ochk(4'h5);
    drv(1'h0);
    ochk(4'hA);
    wr(ADR_CLK, 8'h01);
    tick(2);
    cmp({7'h0, osc}, 8'h01);
    wr(ADR_CLK, 8'h00);
    tick(2);
    cmp({7'h0, osc}, 8'h00);
    $display("test half bridge done");
    // Load bit: self clear, refused in the enabling write
    wr(ADR_CTRL0, 8'hC4);
    rchk(ADR_CTRL0, 8'hC4);
    drv(1'h1);
    drv(1'h0);
    rchk(ADR_CTRL0, 8'h84);
    wr(ADR_CTRL0, 8'h00);
    wr(ADR_CTRL0, 8'hC4);
    rchk(ADR_CTRL0, 8'h84);
    // Reserved modes hold outputs inactive
    for (int m = 6; m < 8; m++) begin
      wr(ADR_CTRL0, {5'h10, m[2:0]});
      drv(1'h1);
      ochk(4'h0);
      drv(1'h0);
    end
    // Tri-state override and a second input source
    wr(ADR_SD0, 8'h94);
    tick(2);
    cmp({4'h0, oe}, 8'h00);
    @(posedge clk_i);
    src <= 4'h2;
    wr(ADR_ISEL, 8'h01);
    rchk(ADR_POL, 8'h20);
    $display("test load and reserved done");
    wrap_up();
  end
endmodule // testbench
